// ---- core/sws_map.vh ----
// Contract
// - Master makes every falling edge except the device presence pulse.
// - Standard speed unless overdrive is set; overdrive uses fast timing everywhere.
// - Reset low of 480 us or more returns the device to standard speed.
// - In overdrive, reset low up to 80 us resets protocol but keeps overdrive.
// - In overdrive, reset low between 80 and 480 us resets; speed undefined.
// - After line rises, wait presence delay, then pull low for presence low time.
// - Reset high window covers presence plus recovery; slots accepted right after.
// - One bit per slot; falling edge starts timer for sampling and read hold.
// - Device needs recovery after rising edge; master waits before next slot.
// - Read zero holds line low until internal timer ends; read one releases.
// - Dips not reaching below the hysteresis level are ignored at both speeds.
// - Dips within rising edge hold-off ignored; longer ones start a slot.
// - Extra falling edge filtering at standard speed, none at overdrive.
// - Chain-on command enters chain-on state and releases the done output.
// - Chain-done drives done output low; conditional identity read then ignored.
// - Chain-off returns both chain pins to software pin control; only the done pin follows the control register bit here.
// - Conditional identity read answered only in chain-on with enable input low.
// - Skip identity command CCh selects the device without address match.
`ifndef SWS_MAP_VH
`define SWS_MAP_VH
`define SWS_CLK_MHZ 250
`define SWS_CW 20
`define SWS_CYC_UP(ns) ((((ns) * `SWS_CLK_MHZ) + 999) / 1000)
`define SWS_CYC_DN(ns) (((ns) * `SWS_CLK_MHZ) / 1000)
`define SWS_T_OD_EXIT_NS 480000
`define SWS_T_OD_KEEP_NS 80000
`define SWS_T_RST_STD_NS 120000
`define SWS_T_RST_OD_NS 16000
`define SWS_T_PDH_STD_NS 30000
`define SWS_T_PDH_OD_NS 3000
`define SWS_T_PDL_STD_NS 120000
`define SWS_T_PDL_OD_NS 12000
`define SWS_T_SMP_STD_NS 30000
`define SWS_T_SMP_OD_NS 3000
`define SWS_T_HLD_STD_NS 30000
`define SWS_T_HLD_OD_NS 3000
`define SWS_T_REH_STD_NS 1000
`define SWS_T_REH_OD_NS 500
`define SWS_T_FLT_STD_NS 200
`define SWS_ROM_SKIP 8'hcc
`define SWS_ROM_OD_SKIP 8'h3c
`define SWS_ROM_COND_READ 8'h0f
`define SWS_FN_CHAIN 8'h99
`define SWS_CH_OFF 8'h3c
`define SWS_CH_ON 8'h5a
`define SWS_CH_DONE 8'h96
`define SWS_A_CTRL 12'h000
`define SWS_A_STAT 12'h004
`define SWS_A_IDLO 12'h008
`define SWS_A_IDHI 12'h00c
`define SWS_CTRL_PIO 0
`define SWS_CTRL_RST 32'h00000000
`define SWS_IDLO_RST 32'h00000028
`define SWS_IDHI_RST 32'h00000000
`endif

// ---- core/sws_frontend.v ----
`timescale 1ns/10ps
`include "sws_map.vh"
module sws_frontend #(
    parameter [11:0] T_FLT = `SWS_CYC_UP(`SWS_T_FLT_STD_NS),
    parameter [11:0] T_REH_STD = `SWS_CYC_DN(`SWS_T_REH_STD_NS),
    parameter [11:0] T_REH_OD = `SWS_CYC_DN(`SWS_T_REH_OD_NS)
)(
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire od,
    input wire line_hi,
    input wire line_dip,
    output reg lvl_q,
    output reg fall_p,
    output reg rise_p
);
reg [11:0] hcnt_q;
reg [11:0] fcnt_q;
wire [11:0] need;
assign need = od ? 12'h000 : (T_FLT - 12'h001);
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        lvl_q <= 1'b1;
        fall_p <= 1'b0;
        rise_p <= 1'b0;
        hcnt_q <= 12'h000;
        fcnt_q <= 12'h000;
    end
    else if (ce)
    begin
        fall_p <= 1'b0;
        rise_p <= 1'b0;
        if (lvl_q)
        begin
            if (hcnt_q != 12'h000)
            begin
                hcnt_q <= hcnt_q - 12'h001;
                fcnt_q <= 12'h000;
            end
            else if (line_dip)
            begin
                if (fcnt_q >= need)
                begin
                    lvl_q <= 1'b0;
                    fall_p <= 1'b1;
                    fcnt_q <= 12'h000;
                end
                else
                    fcnt_q <= fcnt_q + 12'h001;
            end
            else
                fcnt_q <= 12'h000;
        end
        else if (line_hi)
        begin
            lvl_q <= 1'b1;
            rise_p <= 1'b1;
            hcnt_q <= od ? T_REH_OD : T_REH_STD;
        end
    end
end
endmodule

// ---- core/sws_core.v ----
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "sws_map.vh"
module sws_core #(
    parameter [19:0] T_OD_EXIT = `SWS_CYC_UP(`SWS_T_OD_EXIT_NS),
    parameter [19:0] T_OD_KEEP = `SWS_CYC_DN(`SWS_T_OD_KEEP_NS),
    parameter [19:0] T_RST_STD = `SWS_CYC_UP(`SWS_T_RST_STD_NS),
    parameter [19:0] T_RST_OD = `SWS_CYC_UP(`SWS_T_RST_OD_NS),
    parameter [19:0] T_PDH_STD = `SWS_CYC_UP(`SWS_T_PDH_STD_NS),
    parameter [19:0] T_PDH_OD = `SWS_CYC_UP(`SWS_T_PDH_OD_NS),
    parameter [19:0] T_PDL_STD = `SWS_CYC_UP(`SWS_T_PDL_STD_NS),
    parameter [19:0] T_PDL_OD = `SWS_CYC_UP(`SWS_T_PDL_OD_NS),
    parameter [19:0] T_SMP_STD = `SWS_CYC_UP(`SWS_T_SMP_STD_NS),
    parameter [19:0] T_SMP_OD = `SWS_CYC_UP(`SWS_T_SMP_OD_NS),
    parameter [19:0] T_HLD_STD = `SWS_CYC_UP(`SWS_T_HLD_STD_NS),
    parameter [19:0] T_HLD_OD = `SWS_CYC_UP(`SWS_T_HLD_OD_NS)
)(
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire line_hi,
    input wire line_dip,
    output reg line_out,
    output reg line_oe_n,
    input wire chain_enable_input,
    output reg chain_done_output,
    output reg chain_done_oe_n
);
localparam [2:0] S_IDLE = 3'd0;
localparam [2:0] S_SLOT = 3'd1;
localparam [2:0] S_RST = 3'd2;
localparam [2:0] S_PDH = 3'd3;
localparam [2:0] S_PDL = 3'd4;
localparam [2:0] S_PWAIT = 3'd5;
localparam [2:0] P_ROM = 3'd0;
localparam [2:0] P_FUNC = 3'd1;
localparam [2:0] P_TXID = 3'd2;
localparam [2:0] P_CH1 = 3'd3;
localparam [2:0] P_CH2 = 3'd4;
localparam [2:0] P_WAIT = 3'd5;
localparam [1:0] C_OFF = 2'd0;
localparam [1:0] C_ON = 2'd1;
localparam [1:0] C_DONE = 2'd2;

function [19:0] pick;
    input sel_od;
    input [19:0] t_std;
    input [19:0] t_od;
    begin
        pick = sel_od ? t_od : t_std;
    end
endfunction

reg [2:0] st_q;
reg [19:0] cnt_q;
reg bit_q;
reg rd_q;
reg drv_q;
reg od_q;
reg [2:0] pst_q;
reg [7:0] sh_q;
reg [2:0] bc_q;
reg [5:0] idx_q;
reg [7:0] ctl_q;
reg [1:0] chain_q;
reg [31:0] ctrl_q;
reg [31:0] idlo_q;
reg [31:0] idhi_q;
wire lvl;
wire fall_p;
wire rise_p;
wire [63:0] ident;
wire slot_done;
wire rst_done;
wire [7:0] nb;
wire [19:0] cnt_inc;

assign ident = {idhi_q, idlo_q};
assign slot_done = (st_q == S_SLOT) && rise_p;
assign rst_done = (st_q == S_RST) && rise_p;
assign nb = {bit_q, sh_q[7:1]};
assign cnt_inc = (cnt_q == 20'hfffff) ? cnt_q : cnt_q + 20'h00001;

sws_frontend u_fe (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .od(od_q),
    .line_hi(line_hi),
    .line_dip(line_dip),
    .lvl_q(lvl),
    .fall_p(fall_p),
    .rise_p(rise_p)
);

// Line timing
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        st_q <= S_IDLE;
        cnt_q <= 20'h00000;
        bit_q <= 1'b1;
        rd_q <= 1'b0;
        drv_q <= 1'b0;
        line_oe_n <= 1'b1;
        line_out <= 1'b0;
    end
    else if (ce)
    begin
        line_out <= 1'b0;
        case (st_q)
            S_IDLE:
            begin
                if (fall_p)
                begin
                    st_q <= S_SLOT;
                    cnt_q <= 20'h00001;
                    bit_q <= 1'b1;
                    rd_q <= (pst_q == P_TXID);
                    if ((pst_q == P_TXID) && !ident[idx_q])
                    begin
                        drv_q <= 1'b1;
                        line_oe_n <= 1'b0;
                    end
                end
            end
            S_SLOT:
            begin
                cnt_q <= cnt_inc;
                if (drv_q && (cnt_q >= pick(od_q, T_HLD_STD, T_HLD_OD)))
                begin
                    drv_q <= 1'b0;
                    line_oe_n <= 1'b1;
                end
                if (!rd_q && (cnt_q == pick(od_q, T_SMP_STD, T_SMP_OD)) && !lvl)
                    bit_q <= 1'b0;
                if (rise_p)
                    st_q <= S_IDLE;
                else if (!drv_q && (cnt_q >= pick(od_q, T_RST_STD, T_RST_OD)))
                    st_q <= S_RST;
            end
            S_RST:
            begin
                cnt_q <= cnt_inc;
                if (rise_p)
                begin
                    st_q <= S_PDH;
                    cnt_q <= 20'h00001;
                end
            end
            S_PDH:
            begin
                cnt_q <= cnt_inc;
                if (cnt_q >= pick(od_q, T_PDH_STD, T_PDH_OD))
                begin
                    st_q <= S_PDL;
                    cnt_q <= 20'h00001;
                    line_oe_n <= 1'b0;
                end
            end
            S_PDL:
            begin
                cnt_q <= cnt_inc;
                if (cnt_q >= pick(od_q, T_PDL_STD, T_PDL_OD))
                begin
                    st_q <= S_PWAIT;
                    line_oe_n <= 1'b1;
                end
            end
            S_PWAIT:
            begin
                if (lvl)
                    st_q <= S_IDLE;
            end
            default:
                st_q <= S_IDLE;
        endcase
    end
end

// Command layer and speed
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        od_q <= 1'b0;
        pst_q <= P_WAIT;
        sh_q <= 8'h00;
        bc_q <= 3'd0;
        idx_q <= 6'd0;
        ctl_q <= 8'h00;
        chain_q <= C_OFF;
    end
    else if (ce)
    begin
        if (rst_done)
        begin
            pst_q <= P_ROM;
            bc_q <= 3'd0;
            if (cnt_q >= T_OD_EXIT)
                od_q <= 1'b0;
            else if (od_q && (cnt_q > T_OD_KEEP))
                od_q <= 1'b0;
            else
                od_q <= od_q;
        end
        else if (slot_done)
        begin
            if (pst_q == P_TXID)
            begin
                idx_q <= idx_q + 6'd1;
                if (idx_q == 6'd63)
                    pst_q <= P_WAIT;
            end
            else if (pst_q != P_WAIT)
            begin
                sh_q <= nb;
                bc_q <= bc_q + 3'd1;
                if (bc_q == 3'd7)
                begin
                    case (pst_q)
                        P_ROM:
                        begin
                            if (nb == `SWS_ROM_SKIP)
                                pst_q <= P_FUNC;
                            else if (nb == `SWS_ROM_OD_SKIP)
                            begin
                                pst_q <= P_FUNC;
                                od_q <= 1'b1;
                            end
                            else if ((nb == `SWS_ROM_COND_READ) && (chain_q == C_ON)
                                && !chain_enable_input)
                            begin
                                pst_q <= P_TXID;
                                idx_q <= 6'd0;
                            end
                            else
                                pst_q <= P_WAIT;
                        end
                        P_FUNC:
                            pst_q <= (nb == `SWS_FN_CHAIN) ? P_CH1 : P_WAIT;
                        P_CH1:
                        begin
                            ctl_q <= nb;
                            pst_q <= P_CH2;
                        end
                        P_CH2:
                        begin
                            pst_q <= P_WAIT;
                            if (nb == ~ctl_q)
                            begin
                                if (ctl_q == `SWS_CH_ON)
                                    chain_q <= C_ON;
                                else if (ctl_q == `SWS_CH_DONE)
                                    chain_q <= C_DONE;
                                else if (ctl_q == `SWS_CH_OFF)
                                    chain_q <= C_OFF;
                            end
                        end
                        default:
                            pst_q <= P_WAIT;
                    endcase
                end
            end
        end
    end
end

// Chain done pin
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        chain_done_output <= 1'b0;
        chain_done_oe_n <= 1'b1;
    end
    else if (ce)
    begin
        chain_done_output <= 1'b0;
        if (chain_q == C_DONE)
            chain_done_oe_n <= 1'b0;
        else if (chain_q == C_ON)
            chain_done_oe_n <= 1'b1;
        else
            chain_done_oe_n <= ~ctrl_q[`SWS_CTRL_PIO];
    end
end

// APB slave
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        ctrl_q <= `SWS_CTRL_RST;
        idlo_q <= `SWS_IDLO_RST;
        idhi_q <= `SWS_IDHI_RST;
    end
    else if (ce)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        if (psel && !penable)
        begin
            pready <= 1'b1;
            if (paddr == `SWS_A_CTRL)
                prdata <= ctrl_q;
            else if (paddr == `SWS_A_STAT)
                prdata <= {25'h0000000, chain_enable_input, pst_q, chain_q, od_q};
            else if (paddr == `SWS_A_IDLO)
                prdata <= idlo_q;
            else if (paddr == `SWS_A_IDHI)
                prdata <= idhi_q;
            else
                pslverr <= 1'b1;
        end
        else if (psel && penable && pready && pwrite)
        begin
            if (paddr == `SWS_A_CTRL)
                ctrl_q <= {31'h00000000, pwdata[0]};
            else if (paddr == `SWS_A_IDLO)
                idlo_q <= pwdata;
            else if (paddr == `SWS_A_IDHI)
                idhi_q <= pwdata;
        end
    end
end
endmodule

// ---- dv/sws_core_assertions.sv ----
`timescale 1ns/10ps
module sws_core_chk #(
    parameter [19:0] T_PDL_STD = 20'h3c,
    parameter [19:0] T_PDL_OD = 20'hf,
    parameter [19:0] T_HLD_STD = 20'h1e,
    parameter [19:0] T_HLD_OD = 20'h8
)(
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire line_hi,
    input wire line_dip,
    input wire line_out,
    input wire line_oe_n,
    input wire chain_done_output
);
    reg [19:0] lo_cnt_q;
    wire [19:0] lo_cnt_d = line_oe_n ? 20'h0 : lo_cnt_q + {19'h0, ce};
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lo_cnt_q <= 20'h0;
        else
            lo_cnt_q <= lo_cnt_d;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    line_pull_only_a: assert property (line_out == 1'b0)
        else $error("line data not low");
    done_pull_only_a: assert property (chain_done_output == 1'b0)
        else $error("done data not low");
    pull_length_a: assert property ($rose(line_oe_n) |-> lo_cnt_q == T_PDL_STD
        || lo_cnt_q == T_PDL_OD || lo_cnt_q == T_HLD_STD || lo_cnt_q == T_HLD_OD)
        else $error("pull length wrong");
    pull_cause_a: assert property ($fell(line_oe_n) |-> $past(line_dip)
        || ($past(line_hi) && $past(line_hi, 4)))
        else $error("pull without cause");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready too long");
    ready_answer_a: assert property (psel && !penable |=> pready && penable)
        else $error("ready late");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not idle");
    err_decode_a: assert property (pready |-> pslverr == !(paddr == 12'h000
        || paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00c))
        else $error("error flag wrong");
endmodule
bind sws_core sws_core_chk #(.T_PDL_STD(T_PDL_STD), .T_PDL_OD(T_PDL_OD),
    .T_HLD_STD(T_HLD_STD), .T_HLD_OD(T_HLD_OD)) u_chk (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_hi(line_hi), .line_dip(line_dip),
    .line_out(line_out), .line_oe_n(line_oe_n), .chain_done_output(chain_done_output));

// ---- dv/sws_master_model.sv ----
`timescale 1ns/10ps
module sws_master_model (
    input wire pclk,
    input wire line_lo,
    output reg m_low_q,
    output reg m_shallow_q
);
    bit od;
    int gl;
    initial
    begin
        m_low_q = 1'b0;
        m_shallow_q = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic rst_pulse(input int low, output bit pres);
        m_low_q <= 1'b1;
        cyc(low);
        m_low_q <= 1'b0;
        cyc(od ? 14 : 52);
        pres = line_lo;
        cyc(od ? 200 : 400);
    endtask
    task automatic slot(input bit b, output bit r);
        m_low_q <= 1'b1;
        cyc(od ? (b ? 3 : 20) : (b ? 60 : 130));
        m_low_q <= 1'b0;
        cyc(od ? 4 : 10);
        r = !line_lo;
        if (gl > 0)
        begin
            m_low_q <= 1'b1;
            cyc(gl);
            m_low_q <= 1'b0;
        end
        cyc(od ? 150 : 300);
    endtask
    task automatic wr_byte(input logic [7:0] b);
        bit r;
        for (int i = 0; i < 8; i++)
            slot(b[i], r);
    endtask
    task automatic rd_bits(input int n, output logic [63:0] v);
        bit r;
        v = '1;
        for (int i = 0; i < n; i++)
        begin
            slot(1'b1, r);
            v[i] = r;
        end
    endtask
    task automatic dip(input bit deep, input int len);
        if (deep)
            m_low_q <= 1'b1;
        else
            m_shallow_q <= 1'b1;
        cyc(len);
        m_low_q <= 1'b0;
        m_shallow_q <= 1'b0;
        cyc(od ? 150 : 300);
    endtask
endmodule

// ---- dv/sws_core_test.sv ----
`timescale 1ns/10ps
module sws_core_test;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, en_n, ce;
    localparam [19:0] OD_EXIT = 20'h190, OD_KEEP = 20'h64, RST_S = 20'hc8, RST_O = 20'h3c;
    localparam [19:0] PDH_S = 20'h14, PDH_O = 20'h5, PDL_S = 20'h3c, PDL_O = 20'hf;
    localparam [19:0] SMP_S = 20'h1e, SMP_O = 20'h8, HLD_S = 20'h1e, HLD_O = 20'h8;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [63:0] v;
    logic er;
    bit pres;
    wire [31:0] prdata;
    wire pready, pslverr, line_out, line_oe_n, done_q, done_oe_n, m_low, m_shallow;
    wire line_lo = m_low | !line_oe_n;
    int n_mismatch, checked, cyc_cnt;
    always #2 pclk = ~pclk;
    sws_core #(.T_OD_EXIT(OD_EXIT), .T_OD_KEEP(OD_KEEP), .T_RST_STD(RST_S),
        .T_RST_OD(RST_O), .T_PDH_STD(PDH_S), .T_PDH_OD(PDH_O), .T_PDL_STD(PDL_S),
        .T_PDL_OD(PDL_O), .T_SMP_STD(SMP_S), .T_SMP_OD(SMP_O), .T_HLD_STD(HLD_S),
        .T_HLD_OD(HLD_O)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_hi(!(line_lo | m_shallow)), .line_dip(line_lo), .line_out(line_out),
        .line_oe_n(line_oe_n), .chain_enable_input(en_n), .chain_done_output(done_q),
        .chain_done_oe_n(done_oe_n));
    sws_master_model mm (.pclk(pclk), .line_lo(line_lo), .m_low_q(m_low),
        .m_shallow_q(m_shallow));
    task stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n < 50, 1'b1);
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk({er, rd}, {e, exp});
    endtask
    task stat(input logic [1:0] ch, input logic o);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd[2:0], {ch, o});
    endtask
    task tx(input int n, input logic [31:0] w);
        for (int i = 0; i < n; i++)
            mm.wr_byte(w[8*i +: 8]);
    endtask
    always @(posedge pclk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 100000)
        begin
            n_mismatch++;
            stop_test;
        end
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        en_n = 1'b0;
        ce = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(12'h000, 32'h0, 1'b0);
        rchk(12'h008, 32'h28, 1'b0);
        rchk(12'h00c, 32'h0, 1'b0);
        rchk(12'h010, 32'h0, 1'b1);
        apb(1'b1, 12'h008, 32'h89abcdef);
        apb(1'b1, 12'h00c, 32'h01234567);
        apb(1'b1, 12'h004, 32'hffffffff);
        apb(1'b1, 12'h000, 32'h1);
        stat(2'h0, 1'b0);
        rchk(12'h00c, 32'h01234567, 1'b0);
        chk(done_oe_n, 1'b0);
        ce <= 1'b0;
        mm.rst_pulse(500, pres);
        chk(pres, 1'b0);
        ce <= 1'b1;
        mm.rst_pulse(500, pres);
        chk(pres, 1'b1);
        mm.dip(1'b1, 20);
        tx(4, 32'ha55a99cc);
        stat(2'h1, 1'b0);
        chk(done_oe_n, 1'b1);
        mm.rst_pulse(500, pres);
        tx(1, 32'h3c);
        mm.od = 1'b1;
        stat(2'h1, 1'b1);
        en_n <= 1'b1;
        mm.rst_pulse(80, pres);
        chk(pres, 1'b1);
        tx(1, 32'h0f);
        mm.rd_bits(8, v);
        chk(v[7:0], 8'hff);
        en_n <= 1'b0;
        mm.rst_pulse(80, pres);
        tx(1, 32'h0f);
        mm.rd_bits(64, v);
        chk(v, 64'h0123456789abcdef);
        mm.rst_pulse(80, pres);
        mm.gl = 5;
        tx(4, 32'h699699cc);
        mm.gl = 0;
        stat(2'h2, 1'b1);
        chk(done_oe_n, 1'b0);
        mm.rst_pulse(80, pres);
        tx(1, 32'h0f);
        mm.rd_bits(8, v);
        chk(v[7:0], 8'hff);
        mm.rst_pulse(80, pres);
        mm.dip(1'b0, 40);
        tx(4, 32'hc33c99cc);
        stat(2'h0, 1'b1);
        apb(1'b1, 12'h000, 32'h0);
        repeat (2) @(posedge pclk);
        chk(done_oe_n, 1'b1);
        mm.rst_pulse(250, pres);
        apb(1'b0, 12'h004, 32'h0);
        mm.od = rd[0];
        chk(rd[5:3], 3'h0);
        tx(1, 32'h3c);
        mm.od = 1'b1;
        stat(2'h0, 1'b1);
        mm.od = 1'b0;
        mm.rst_pulse(500, pres);
        chk(pres, 1'b1);
        stat(2'h0, 1'b0);
        stop_test;
    end
endmodule
